// ==== bench/tb.sv ====
// self-checking bench for the transmit fifo level tracker
`timescale 1ns/1ns
`include "tfl_defs.svh"
module tb
  import tfl_pkg::*;
;
  logic sys_clk, sys_rst, ce, hsel, hwrite, wr_valid, wr_last, wr_rewind, stall;
  logic [31:0] haddr, hwdata, wr_data, hrdata, tx_data, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, wr_ready, tx_valid, tx_ready, tx_last;
  tfl_cell_t exp_cell [0:63];
  int fail_count, n_checks, n_exp;

  tfl_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .wr_last(wr_last), .wr_rewind(wr_rewind),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
  tfl_reader_model rdr (.sys_clk(sys_clk), .sys_rst(sys_rst), .stall(stall),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single transfer; each phase waits for hready at a rising edge
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask

  task rd_chk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000, rv);
    chk(rv, e);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  // expected register words from the field positions
  function automatic logic [31:0] lvl(input logic [11:0] r, input logic [11:0] w);
    return {4'h0, r, 4'h0, w};
  endfunction
  function automatic logic [31:0] ptr(input logic [10:0] r, input logic [10:0] w);
    return {5'h00, r, 5'h00, w};
  endfunction

  // writer: words back to back; kept words are recorded as expected output
  task send(input int base, input int n, input logic fin, input logic keep);
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_data <= 32'hA5A5_0000 + 32'(base + i);
      wr_last <= fin && (i == n - 1);
      if (keep) begin
        exp_cell[n_exp] = {fin && (i == n - 1), 32'hA5A5_0000 + 32'(base + i)};
        n_exp++;
      end
      @(posedge sys_clk);
      while (wr_ready !== 1'b1) @(posedge sys_clk);
    end
    wr_valid <= 1'b0;
    wr_last <= 1'b0;
    // one idle edge so a following call never re-raises valid in this time step
    @(posedge sys_clk);
  endtask

  task test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    {hsel, hwrite, wr_valid, wr_last, wr_rewind, stall} = 6'h00;
    {haddr, hwdata, wr_data} = 96'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    fail_count = 0;
    n_checks = 0;
    n_exp = 0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(`TFL_LVL_ADDR, lvl(12'h000, 12'h000));
    rd_chk(`TFL_PTR_ADDR, ptr(11'h000, 11'h000));
    rd_chk(32'h0000_0040, 32'h0000_0000);
    // registers are read-only, a write leaves them alone
    ahb(1'b1, `TFL_LVL_ADDR, 32'hFFFF_FFFF, rv);
    rd_chk(`TFL_LVL_ADDR, lvl(12'h000, 12'h000));
    // clock enable low stalls bus and writer
    ce <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({30'h0000_0000, hreadyout, wr_ready}, 32'h0000_0000);
    @(posedge sys_clk);
    ce <= 1'b1;
    // reader stalled so that words pile up
    stall <= 1'b1;
    send(0, 2, 1'b0, 1'b1);
    rd_chk(`TFL_LVL_ADDR, lvl(12'h000, 12'h002));
    rd_chk(`TFL_PTR_ADDR, ptr(11'h000, 11'h002));
    send(2, 1, 1'b1, 1'b1);
    repeat (8) @(posedge sys_clk);
    rd_chk(`TFL_LVL_ADDR, lvl(12'h000, 12'h000));
    rd_chk(`TFL_PTR_ADDR, ptr(11'h003, 11'h003));
    // partial packet thrown away, then sent again
    send(32, 2, 1'b0, 1'b0);
    rd_chk(`TFL_LVL_ADDR, lvl(12'h000, 12'h002));
    wr_rewind <= 1'b1;
    @(posedge sys_clk);
    wr_rewind <= 1'b0;
    rd_chk(`TFL_LVL_ADDR, lvl(12'h000, 12'h000));
    rd_chk(`TFL_PTR_ADDR, ptr(11'h003, 11'h003));
    send(3, 2, 1'b1, 1'b1);
    // long packet overflows the output buffer and leaves a read-side level
    send(5, 19, 1'b0, 1'b1);
    rd_chk(`TFL_LVL_ADDR, lvl(12'h000, 12'h013));
    send(24, 1, 1'b1, 1'b1);
    repeat (30) @(posedge sys_clk);
    rd_chk(`TFL_LVL_ADDR, lvl(12'h009, 12'h014));
    rd_chk(`TFL_PTR_ADDR, ptr(11'h010, 11'h019));
    // release the reader and let everything drain
    stall <= 1'b0;
    repeat (40) @(posedge sys_clk);
    rd_chk(`TFL_LVL_ADDR, lvl(12'h000, 12'h000));
    rd_chk(`TFL_PTR_ADDR, ptr(11'h019, 11'h019));
    chk({31'h0000_0000, tx_valid}, 32'h0000_0000);
    chk(32'(rdr.got_n_ff), 32'(n_exp));
    for (int i = 0; i < n_exp; i++) begin
      chk(rdr.got_ff[i][31:0], exp_cell[i][31:0]);
      chk({31'h0000_0000, rdr.got_ff[i][32]}, {31'h0000_0000, exp_cell[i][32]});
    end
    test_done;
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    test_done;
  end
endmodule

// ==== bench/tfl_reader_model.sv ====
// transmit reader model that collects drained words and can stall
`timescale 1ns/1ns
module tfl_reader_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // stall request from the bench
  input wire logic stall,
  // fifo drain side
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [31:0] tx_data,
  input wire logic tx_last
);
  logic [32:0] got_ff [0:63];
  int got_n_ff;
  // ready is the inverse of the stall request, so a stall holds words in the fifo
  assign tx_ready = !stall;
  // keep each of the first 64 words taken at a handshake edge, in arrival order
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      got_n_ff <= 0;
    end else if (tx_valid && tx_ready && got_n_ff < 64) begin
      got_ff[got_n_ff] <= {tx_last, tx_data};
      got_n_ff <= got_n_ff + 1;
    end
  end
endmodule

// ==== inc/tfl_defs.svh ====
// constants for the transmit fifo level tracker
`ifndef TFL_DEFS_SVH
`define TFL_DEFS_SVH
`define TFL_DATA_W 32
`define TFL_LVL_W 12
`define TFL_PTR_W 11
`define TFL_DEPTH 12'h800
`define TFL_BUF_DEPTH 16
`define TFL_PTR_LAST 11'h7ff
`define TFL_PTR_ONE 11'h001
`define TFL_LVL_ONE 12'h001
`define TFL_LVL_RST 12'h000
`define TFL_PTR_RST 11'h000
`define TFL_LVL_ADDR 32'h0000_0078
`define TFL_PTR_ADDR 32'h0000_007c
`define TFL_ADDR_MSB 7
`define TFL_LVL_PAD 4'h0
`define TFL_PTR_PAD 5'h00
`define TFL_WORD_RST 32'h0000_0000
`define TFL_RDP_MSB 26
`define TFL_RDP_LSB 16
`define TFL_WRP_MSB 10
`define TFL_WRP_LSB 0
`endif

// ==== inc/tfl_pkg.sv ====
// shared types for the transmit fifo level tracker
`include "tfl_defs.svh"
package tfl_pkg;
  typedef logic [`TFL_LVL_W-1:0] tfl_lvl_t;
  typedef logic [`TFL_PTR_W-1:0] tfl_ptr_t;
  typedef logic [`TFL_DATA_W-1:0] tfl_word_t;
  // stored word carries its end-of-packet mark above the data
  typedef logic [`TFL_DATA_W:0] tfl_cell_t;
endpackage

// ==== rtl/tfl_fifo.sv ====
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`include "tfl_defs.svh"
module tfl_fifo #(
  parameter int WIDTH = `TFL_DATA_W + 1,
  parameter int DEPTH = `TFL_BUF_DEPTH
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_idx_ff;
  logic [AW-1:0] rd_idx_ff;
  logic [AW:0] count_ff;
  wire push = ce && in_valid && in_ready;
  wire pop = ce && out_valid && out_ready;

  // honest full and empty from the occupancy count; the count is one bit
  // wider than the index so a full buffer is not mistaken for an empty one
  assign in_ready = (count_ff != (AW+1)'(DEPTH)) && ce;
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_idx_ff];

  // storage, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_idx_ff] <= in_data;
    end
  end

  // indices wrap naturally since depth is a power of two
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_idx_ff <= wr_idx_ff + AW'(1);
      if (pop) rd_idx_ff <= rd_idx_ff + AW'(1);
      if (push != pop) count_ff <= push ? count_ff + (AW+1)'(1) : count_ff - (AW+1)'(1);
    end
  end
endmodule

// ==== rtl/tfl_top.sv ====
// transmit fifo with packet level tracking, rewind and debug registers
// Function
// [R1] The read-side count rises by a packet's full length only once the whole packet is written.
// [R2] The read-side count drops by one for every word the reader removes. The code drops it as each word enters the output buffer.
// [R3] The read side offers no rewind; removed words never return to the fifo or its count.
// [R4] The write-side count rises by one for every word written.
// [R5] The write-side count drops by a packet's length only when that packet is fully read out. The code drops it as its last word enters the output buffer.
// [R6] A rewind subtracts the partial packet's word count from the write-side count.
// [R7] A packet received with an error is rewound out and accepted again on resend.
// [R8] The read pointer shows in bits 26:16 of the pointer debug register, reset zero.
// [R9] The write pointer shows in bits 10:0 of the pointer debug register, reset zero.
// [R10] Pointers step once per word and wrap; a rewind returns the write pointer to packet start.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "tfl_defs.svh"
module tfl_top
  import tfl_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // writer side (usb bulk-out path)
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_data,
  input wire logic wr_last,
  input wire logic wr_rewind,
  // reader side (mac transmit path)
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_data,
  output logic tx_last
);

  // pointer step with explicit wrap at the storage end
  function automatic tfl_ptr_t tfl_ptr_inc(input tfl_ptr_t p);
    tfl_ptr_inc = (p == `TFL_PTR_LAST) ? `TFL_PTR_RST : p + `TFL_PTR_ONE;
  endfunction

  // packet length from a zero-based word count
  function automatic tfl_lvl_t tfl_len(input tfl_lvl_t cnt);
    tfl_len = cnt + `TFL_LVL_ONE;
  endfunction

  // tracked state
  tfl_cell_t store_ff [`TFL_DEPTH];
  tfl_ptr_t fill_ptr_ff;
  tfl_ptr_t nxt_fill_ptr;
  tfl_ptr_t drain_ptr_ff;
  tfl_ptr_t pkt_start_ff;
  tfl_lvl_t cur_len_ff;
  tfl_lvl_t drain_len_ff;
  tfl_lvl_t rd_lvl_ff;
  tfl_lvl_t wr_lvl_ff;
  tfl_lvl_t nxt_rd_lvl;
  tfl_lvl_t nxt_wr_lvl;
  tfl_word_t hrdata_ff;

  // handshake decode
  wire rewind = ce && wr_rewind;
  wire wr_fire = wr_valid && wr_ready;
  wire commit = wr_fire && wr_last;
  wire buf_in_ready;
  wire rd_fire = ce && (rd_lvl_ff != `TFL_LVL_RST) && buf_in_ready;
  tfl_cell_t rd_cell;
  assign rd_cell = store_ff[drain_ptr_ff];
  wire pkt_done = rd_fire && rd_cell[`TFL_DATA_W];

  // write level covers every stored word, so it bounds the free space;
  // a rewind cycle refuses data so the discarded packet stays intact
  assign wr_ready = ce && !wr_rewind && (wr_lvl_ff != `TFL_DEPTH);

  // level arithmetic
  wire tfl_lvl_t commit_amt = commit ? tfl_len(cur_len_ff) : `TFL_LVL_RST;
  wire tfl_lvl_t drain_amt = rd_fire ? `TFL_LVL_ONE : `TFL_LVL_RST;
  wire tfl_lvl_t fill_amt = wr_fire ? `TFL_LVL_ONE : `TFL_LVL_RST;
  wire tfl_lvl_t done_amt = pkt_done ? tfl_len(drain_len_ff) : `TFL_LVL_RST;
  wire tfl_lvl_t rewind_amt = rewind ? cur_len_ff : `TFL_LVL_RST;

  // [R1] whole-packet commit
  // [R2] per-word drain
  // [R3] nothing is ever added back on the read side
  assign nxt_rd_lvl = rd_lvl_ff + commit_amt - drain_amt;

  // [R4] per-word fill
  // [R5] packet release as its last word enters the output buffer
  // [R6] partial packet removed
  assign nxt_wr_lvl = wr_lvl_ff + fill_amt - done_amt - rewind_amt;

  // [R10] step on write, return to packet start on rewind
  assign nxt_fill_ptr = rewind ? pkt_start_ff :
                        wr_fire ? tfl_ptr_inc(fill_ptr_ff) : fill_ptr_ff;

  // word storage, flip-flops indexed by the fill pointer
  always_ff @(posedge sys_clk) begin
    if (wr_fire) begin
      store_ff[fill_ptr_ff] <= {wr_last, wr_data};
    end
  end

  // level counters
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_lvl_ff <= `TFL_LVL_RST;
      wr_lvl_ff <= `TFL_LVL_RST;
    end else if (ce) begin
      rd_lvl_ff <= nxt_rd_lvl;
      wr_lvl_ff <= nxt_wr_lvl;
    end
  end

  // [R7] write-side packet tracking; a rewind drops the partial packet
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fill_ptr_ff <= `TFL_PTR_RST;
      pkt_start_ff <= `TFL_PTR_RST;
      cur_len_ff <= `TFL_LVL_RST;
    end else if (ce) begin
      fill_ptr_ff <= nxt_fill_ptr;
      if (rewind) begin
        cur_len_ff <= `TFL_LVL_RST;
      end else if (commit) begin
        cur_len_ff <= `TFL_LVL_RST;
        pkt_start_ff <= nxt_fill_ptr;
      end else if (wr_fire) begin
        cur_len_ff <= tfl_len(cur_len_ff);
      end
    end
  end

  // [R10] read pointer steps once per word drained
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drain_ptr_ff <= `TFL_PTR_RST;
      drain_len_ff <= `TFL_LVL_RST;
    end else if (rd_fire) begin
      drain_ptr_ff <= tfl_ptr_inc(drain_ptr_ff);
      drain_len_ff <= pkt_done ? `TFL_LVL_RST : tfl_len(drain_len_ff);
    end
  end

  // output buffer decouples the mac from the tracked storage;
  // its back-pressure stalls draining, which keeps the counts exact
  tfl_fifo #(
    .WIDTH(`TFL_DATA_W + 1),
    .DEPTH(`TFL_BUF_DEPTH)
  ) u_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(rd_fire),
    .in_ready(buf_in_ready),
    .in_data(rd_cell),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data({tx_last, tx_data})
  );

  // ahb address phase decode; writes are accepted and ignored
  wire ahb_take = ce && hsel && htrans[1] && hready;
  wire [`TFL_ADDR_MSB:0] reg_addr = haddr[`TFL_ADDR_MSB:0];
  wire hit_lvl = (reg_addr == `TFL_LVL_ADDR);
  wire hit_ptr = (reg_addr == `TFL_PTR_ADDR);
  wire tfl_word_t lvl_word = {`TFL_LVL_PAD, rd_lvl_ff, `TFL_LVL_PAD, wr_lvl_ff};
  // [R8] [R9] pointer layout
  wire tfl_word_t ptr_word = {`TFL_PTR_PAD, drain_ptr_ff, `TFL_PTR_PAD, fill_ptr_ff};
  wire tfl_word_t rd_word = hit_lvl ? lvl_word : hit_ptr ? ptr_word : `TFL_WORD_RST;

  // read data captured at the address phase, shown in the data phase
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_ff <= `TFL_WORD_RST;
    end else if (ahb_take && !hwrite) begin
      hrdata_ff <= rd_word;
    end
  end

  // zero wait states; a frozen block holds the bus through hreadyout
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // checks, all but a_rewind_refuse relative to the enabled clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_rdlvl_commit: assert property ( // [R1]
    ce && commit && !rd_fire
      |=> rd_lvl_ff == $past(rd_lvl_ff) + $past(cur_len_ff) + `TFL_LVL_ONE
  ) else $error("read level did not rise by packet length on commit");

  a_rdlvl_hold: assert property ( // [R1]
    ce && !commit && !rd_fire |=> rd_lvl_ff == $past(rd_lvl_ff)
  ) else $error("read level changed without commit or drain");

  a_rdlvl_drain: assert property ( // [R2]
    ce && rd_fire && !commit |=> rd_lvl_ff == $past(rd_lvl_ff) - `TFL_LVL_ONE
  ) else $error("read level did not drop by one on drain");

  a_no_read_rewind: assert property ( // [R3]
    ce && !commit |=> rd_lvl_ff <= $past(rd_lvl_ff)
  ) else $error("read level grew without a committed packet");

  a_wrlvl_fill: assert property ( // [R4]
    ce && wr_fire && !pkt_done |=> wr_lvl_ff == $past(wr_lvl_ff) + `TFL_LVL_ONE
  ) else $error("write level did not rise by one per word");

  a_wrlvl_release: assert property ( // [R5]
    ce && pkt_done && !wr_fire && !rewind
      |=> wr_lvl_ff == $past(wr_lvl_ff) - $past(drain_len_ff) - `TFL_LVL_ONE
  ) else $error("write level not released by packet length");

  a_wrlvl_rewind: assert property ( // [R6]
    ce && rewind && !pkt_done |=> wr_lvl_ff == $past(wr_lvl_ff) - $past(cur_len_ff)
  ) else $error("rewind did not remove the partial packet");

  a_rewind_ptr: assert property ( // [R7]
    ce && rewind |=> fill_ptr_ff == $past(pkt_start_ff) && cur_len_ff == `TFL_LVL_RST
  ) else $error("rewind did not return fill pointer to packet start");

  a_rewind_refuse: assert property ( // [R7]
    wr_rewind |-> !wr_ready
  ) else $error("data accepted during rewind");

  a_drain_step: assert property ( // [R10]
    ce && rd_fire |=> drain_ptr_ff == $past(drain_ptr_ff) + `TFL_PTR_ONE
  ) else $error("read pointer did not step by one");

  a_ptr_readback: assert property ( // [R8]
    ahb_take && !hwrite && hit_ptr
      |=> hrdata[`TFL_RDP_MSB:`TFL_RDP_LSB] == $past(drain_ptr_ff)
        && hrdata[`TFL_WRP_MSB:`TFL_WRP_LSB] == $past(fill_ptr_ff)
  ) else $error("pointer register read back wrong");

  a_fill_step: assert property ( // [R10]
    ce && wr_fire && !rewind |=> fill_ptr_ff == $past(fill_ptr_ff) + `TFL_PTR_ONE
  ) else $error("write pointer did not step by one");
endmodule
